// ---- rtl/tvs_pkg.sv ----
// Shared constants and types for the TV standard select controller pair.
//------------------------------------------------------------------------
// Summary of operation
// - 625 lines: 17.7 reference, SECAM/PAL/kill
// - 525 lines: 14.3 reference, NTSC or kill
// - No flags on 14.3: retry 17.7
// - User controls written only in field flyback
// - User writes end within 1.0 ms
// - Only the data byte needs the window
// - Processor applies user controls unbuffered
// - Other control data written any time
// - Grid flags near black-level converter range ends
// - No range flags for gain converters
// - Grid set-up watches lower then raise flag
// - PAL and SECAM flags never both set
// - Below 576 lines means 525-line signal
// - Burst flag follows burst level and noise
//------------------------------------------------------------------------
package tvs_pkg;

   // Clock and timing, times in nanoseconds.
   localparam int CLK_PERIOD_NS        = 100;
   localparam int FLYBACK_TO_SAMPLE_NS = 1200000;
   localparam int WRITE_WINDOW_NS      = 1000000;
   localparam int SAMPLE_START_CYC     = FLYBACK_TO_SAMPLE_NS / CLK_PERIOD_NS;
   localparam int WRITE_WINDOW_CYC     = WRITE_WINDOW_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_LEN_CYC       = 200;
   localparam int SETTLE_FIELDS        = 4;

   // Processor-side detection thresholds.
   localparam logic [9:0] LINE_LIMIT     = 10'h240;
   localparam logic [7:0] BURST_THRESH   = 8'h30;
   localparam logic [7:0] ID_MIN_SCORE   = 8'h40;
   localparam int         GRID_MARGIN_PCT = 15;

   // Link write addresses.
   localparam int         NUM_UC     = 4;
   localparam logic [2:0] LA_BRIGHT  = 3'h0;
   localparam logic [2:0] LA_CTRL    = 3'h4;
   localparam int         CTRL_NORM  = 0;

   // Bit positions in the returned flag byte.
   localparam int FL_LT576 = 0;
   localparam int FL_BURST = 1;
   localparam int FL_PAL   = 2;
   localparam int FL_SECAM = 3;
   localparam int FL_RAISE = 4;
   localparam int FL_LOWER = 5;
   localparam int FL_OK    = 6;
   localparam int FL_FAULT = 7;

   // Controller register byte offsets.
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_INT_EN  = 8'h08;
   localparam logic [7:0] REG_INT_CLR = 8'h0c;
   localparam logic [7:0] REG_STD     = 8'h10;
   localparam logic [7:0] REG_UC      = 8'h14;
   localparam logic [7:0] REG_OTHER   = 8'h18;
   localparam logic [7:0] REG_FLAGS   = 8'h1c;

   // Control bits, status events and reset values.
   localparam int         CTRL_AUTO   = 0;
   localparam logic [0:0] CTRL_RST    = 1'h1;
   localparam int         EV_STD      = 0;
   localparam int         EV_BUSERR   = 1;
   localparam int         EV_RAISE    = 2;
   localparam int         EV_LOWER    = 3;
   localparam int         EV_UC_DONE  = 4;
   localparam int         NUM_EV      = 5;
   localparam logic [7:0] CTRL4_RST   = 8'h00;

   typedef enum logic [2:0] {
      STD_KILL, STD_PAL, STD_SECAM, STD_NTSC, STD_NTSC_KILL, STD_BUS_ERR
   } tvs_std_type;

   typedef enum logic [1:0] {
      XS_17M7, XS_14M3, XS_HYBRID
   } tvs_xtal_state_type;

endpackage

// ---- rtl/tvs_link_if.sv ----
// Link between the video processor end and the controller end.
`timescale 1ns/10ps
`default_nettype none
interface tvs_link_if;
   logic [7:0] flags;     // Returned status flags.
   logic       flyback;   // Field flyback level.
   logic       wr_valid;  // One-cycle control write.
   logic [2:0] wr_addr;   // Control write address.
   logic [7:0] wr_data;   // Control write data byte.

   modport dev  (output flags, output flyback,
                 input wr_valid, input wr_addr, input wr_data);
   modport host (input flags, input flyback,
                 output wr_valid, output wr_addr, output wr_data);
endinterface
`default_nettype wire

// ---- rtl/tvs_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module tvs_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,  // System clock.
   input  wire logic         rst_n,     // Asynchronous reset, active low.
   input  wire logic         ce,        // Clock enable.
   input  wire logic [W-1:0] d,         // Asynchronous inputs.
   output logic      [W-1:0] q          // Synchronised outputs.
);
   logic [W-1:0] meta_q;

   // Only the second stage is visible; multi-bit fields must be static.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tvs_vproc_end.sv ----
// Video processor end: flag generation, flyback timing, control storage.
`timescale 1ns/10ps
`default_nettype none
module tvs_vproc_end #(
   parameter int SAMPLE_START = tvs_pkg::SAMPLE_START_CYC,
   parameter int SAMPLE_LEN   = tvs_pkg::SAMPLE_LEN_CYC,
   parameter int DAC_W        = 8
) (
   input  wire logic             core_clk,      // System clock.
   input  wire logic             rst_n,         // Async reset, active low.
   input  wire logic             ce,            // Clock enable.
   input  wire logic [9:0]       line_count,    // Lines per field, pin.
   input  wire logic [7:0]       burst_level,   // Back porch burst, pin.
   input  wire logic             noisy,         // Signal too noisy, pin.
   input  wire logic [7:0]       pal_score,     // PAL swing strength.
   input  wire logic [7:0]       secam_score,   // SECAM carrier strength.
   input  wire logic [3*DAC_W-1:0] black_dac,   // Black-level converters.
   input  wire logic             flyback_pin,   // Field flyback, pin.
   tvs_link_if.dev               link,          // Link to controller.
   output logic [3:0][7:0]       user_ctrl,     // Bright/contr/sat/hue.
   output logic [3:0][7:0]       other_ctrl,    // Other control bytes.
   output logic                  rgb_sampling,  // RGB loops sampling.
   output logic                  loop_bounce    // User write hit sampling.
);
   localparam int PW = 10 + 8 + 1 + 8 + 8 + 3 * DAC_W + 1;
   localparam int CW = $clog2(SAMPLE_START + SAMPLE_LEN + 1);
   localparam logic [DAC_W-1:0] DAC_MAX = {DAC_W{1'b1}};
   localparam logic [DAC_W-1:0] MARGIN  =
      DAC_W'((2 ** DAC_W - 1) * tvs_pkg::GRID_MARGIN_PCT / 100);

   logic [PW-1:0]        pins_s;
   logic [9:0]           line_s;
   logic [7:0]           burst_s;
   logic                 noisy_s;
   logic [7:0]           pal_s;
   logic [7:0]           secam_s;
   logic [3*DAC_W-1:0]   dac_s;
   logic                 fly_s;
   logic                 fly_q;
   logic [2:0]           near_top;
   logic [2:0]           near_bot;
   logic                 pal_id;
   logic                 secam_id;
   logic [7:0]           flags_q;
   logic [CW-1:0]        cnt_q;
   logic                 run_q;

   // All detector inputs arrive from the analog side.
   tvs_sync #(.W(PW)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .d        ({line_count, burst_level, noisy, pal_score,
                  secam_score, black_dac, flyback_pin}),
      .q        (pins_s)
   );
   assign {line_s, burst_s, noisy_s, pal_s, secam_s, dac_s, fly_s} = pins_s;

   for (genvar i = 0; i < 3; i++) begin : g_grid
      assign near_top[i] = dac_s[i*DAC_W +: DAC_W] >= DAC_MAX - MARGIN;
      assign near_bot[i] = dac_s[i*DAC_W +: DAC_W] <= MARGIN;
   end

   assign pal_id   = (pal_s >= tvs_pkg::ID_MIN_SCORE) && (pal_s > secam_s);
   assign secam_id = (secam_s >= tvs_pkg::ID_MIN_SCORE) && !pal_id;

   // Flag byte; OK wired high and fault wired low as a link check.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= 8'h40;
      end else if (ce) begin
         flags_q[tvs_pkg::FL_LT576] <= line_s < tvs_pkg::LINE_LIMIT;
         flags_q[tvs_pkg::FL_BURST] <= (burst_s >= tvs_pkg::BURST_THRESH) &&
                                       !noisy_s;
         flags_q[tvs_pkg::FL_PAL]   <= pal_id;
         flags_q[tvs_pkg::FL_SECAM] <= secam_id;
         flags_q[tvs_pkg::FL_RAISE] <= |near_bot;
         flags_q[tvs_pkg::FL_LOWER] <= |near_top;
         flags_q[tvs_pkg::FL_OK]    <= 1'b1;
         flags_q[tvs_pkg::FL_FAULT] <= 1'b0;
      end
   end
   assign link.flags   = flags_q;
   assign link.flyback = fly_q;

   // Flyback edge starts the count to the RGB sampling slot.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fly_q        <= 1'b0;
         run_q        <= 1'b0;
         cnt_q        <= '0;
         rgb_sampling <= 1'b0;
      end else if (ce) begin
         fly_q <= fly_s;
         if (fly_s && !fly_q) begin
            run_q <= 1'b1;
            cnt_q <= CW'(1);
         end else if (run_q) begin
            cnt_q <= cnt_q + CW'(1);
            if (cnt_q == CW'(SAMPLE_START))
               rgb_sampling <= 1'b1;
            if (cnt_q == CW'(SAMPLE_START + SAMPLE_LEN - 1)) begin
               rgb_sampling <= 1'b0;
               run_q        <= 1'b0;
            end
         end
      end
   end

   // Control writes land at once; there is no shadow for the drives.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         user_ctrl   <= '0;
         other_ctrl  <= '0;
         loop_bounce <= 1'b0;
      end else if (ce) begin
         loop_bounce <= 1'b0;
         if (link.wr_valid) begin
            if (link.wr_addr < tvs_pkg::LA_CTRL) begin
               user_ctrl[link.wr_addr[1:0]] <= link.wr_data;
               loop_bounce <= rgb_sampling;
            end else begin
               other_ctrl[link.wr_addr[1:0]] <= link.wr_data;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tvs_ctrl_end.sv ----
// Controller end: standard selection, reference choice, write timing.
`timescale 1ns/10ps
`default_nettype none
module tvs_ctrl_end #(
   parameter int WIN_CYC = tvs_pkg::WRITE_WINDOW_CYC,
   parameter int SETTLE  = tvs_pkg::SETTLE_FIELDS
) (
   input  wire logic           core_clk,   // System clock.
   input  wire logic           rst_n,      // Async reset, active low.
   input  wire logic           ce,         // Clock enable.
   input  wire logic [7:0]     reg_addr,   // Register byte address.
   input  wire logic [31:0]    reg_wdata,  // Register write data.
   input  wire logic           reg_wr,     // Write strobe.
   input  wire logic           reg_rd,     // Read strobe.
   output logic      [31:0]    reg_rdata,  // Read data, cycle after.
   output logic                irq,        // Level interrupt.
   output tvs_pkg::tvs_std_type std_sel,   // Selected standard.
   output logic                xtal_14m3,  // Reference: 1 = 14.3 MHz.
   tvs_link_if.host            link        // Link to processor.
);
   logic [0:0]                      ctrl_q;
   logic [tvs_pkg::NUM_EV-1:0]      st_q;
   logic [tvs_pkg::NUM_EV-1:0]      st_d;
   logic [tvs_pkg::NUM_EV-1:0]      en_q;
   logic [tvs_pkg::NUM_EV-1:0]      ev;
   logic [tvs_pkg::NUM_EV-1:0]      clr;
   tvs_pkg::tvs_xtal_state_type     xs_q;
   logic [7:0]                      fld_q;
   logic                            fly_q;
   logic                            fly_rise;
   logic                            no_id;
   logic                            win_q;
   logic [15:0]                     win_cnt_q;
   tvs_pkg::tvs_std_type            std_d;
   logic [3:0]                      uc_pend_q;
   logic [3:0][7:0]                 uc_val_q;
   logic [1:0]                      uc_sel;
   logic                            sw_pend_q;
   logic [2:0]                      sw_addr_q;
   logic [7:0]                      sw_data_q;
   logic                            norm_pend_q;
   logic [7:0]                      ctrl4_q;
   logic                            send_norm;
   logic                            send_sw;
   logic                            send_uc;
   logic                            wr_valid_q;
   logic [2:0]                      wr_addr_q;
   logic [7:0]                      wr_data_q;
   logic                            want_14m3;
   logic                            wr_hit;

   assign fly_rise = link.flyback && !fly_q;
   assign no_id    = !(link.flags[tvs_pkg::FL_BURST] ||
                       link.flags[tvs_pkg::FL_PAL] ||
                       link.flags[tvs_pkg::FL_SECAM]);
   assign want_14m3 = (xs_q == tvs_pkg::XS_14M3);
   assign wr_hit   = reg_wr;

   // Flag table lookup for the reference currently in use.
   function automatic tvs_pkg::tvs_std_type decode_std(
      input logic [7:0] f,
      input logic       use_14m3
   );
      tvs_pkg::tvs_std_type s;
      s = tvs_pkg::STD_KILL;
      if ((f[tvs_pkg::FL_PAL] && f[tvs_pkg::FL_SECAM]) ||
          !f[tvs_pkg::FL_OK] || f[tvs_pkg::FL_FAULT]) begin
         s = tvs_pkg::STD_BUS_ERR;
      end else if (!use_14m3) begin
         if (f[tvs_pkg::FL_SECAM])
            s = tvs_pkg::STD_SECAM;
         else if (f[tvs_pkg::FL_BURST] && f[tvs_pkg::FL_PAL])
            s = tvs_pkg::STD_PAL;
      end else begin
         s = f[tvs_pkg::FL_BURST] ? tvs_pkg::STD_NTSC : tvs_pkg::STD_NTSC_KILL;
      end
      return s;
   endfunction

   assign std_d = decode_std(link.flags, want_14m3);

   //---------------------------------------------------------------------
   // Reference selection
   //---------------------------------------------------------------------

   // Evaluated once per field so flags settle after a reference swap.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xs_q  <= tvs_pkg::XS_17M7;
         fld_q <= 8'h00;
         fly_q <= 1'b0;
      end else if (ce) begin
         fly_q <= link.flyback;
         if (fly_rise && ctrl_q[tvs_pkg::CTRL_AUTO]) begin
            case (xs_q)
               tvs_pkg::XS_17M7: begin
                  if (link.flags[tvs_pkg::FL_LT576]) begin
                     xs_q  <= tvs_pkg::XS_14M3;
                     fld_q <= 8'h00;
                  end
               end
               tvs_pkg::XS_14M3, tvs_pkg::XS_HYBRID: begin
                  if (!link.flags[tvs_pkg::FL_LT576]) begin
                     xs_q <= tvs_pkg::XS_17M7;
                  end else if (!no_id) begin
                     fld_q <= 8'h00;
                  end else if (fld_q == 8'(SETTLE - 1)) begin
                     // no flag: try the other reference
                     xs_q  <= (xs_q == tvs_pkg::XS_14M3) ?
                              tvs_pkg::XS_HYBRID : tvs_pkg::XS_14M3;
                     fld_q <= 8'h00;
                  end else begin
                     fld_q <= fld_q + 8'h01;
                  end
               end
               default: xs_q <= tvs_pkg::XS_17M7;
            endcase
         end
      end
   end

   // Standard and reference outputs, reference change queued for link.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         std_sel     <= tvs_pkg::STD_KILL;
         xtal_14m3   <= 1'b0;
         norm_pend_q <= 1'b0;
      end else if (ce) begin
         std_sel <= std_d;
         if (send_norm)
            norm_pend_q <= 1'b0;
         if (want_14m3 != xtal_14m3) begin
            xtal_14m3   <= want_14m3;
            norm_pend_q <= 1'b1;
         end
      end
   end

   //---------------------------------------------------------------------
   // Write timing
   //---------------------------------------------------------------------

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_q     <= 1'b0;
         win_cnt_q <= 16'h0000;
      end else if (ce) begin
         if (fly_rise) begin
            win_q     <= 1'b1;
            win_cnt_q <= 16'h0000;
         end else if (win_q) begin
            win_cnt_q <= win_cnt_q + 16'h0001;
            if (win_cnt_q == 16'(WIN_CYC - 1))
               win_q <= 1'b0;
         end
      end
   end

   // Lowest pending user control goes first.
   always_comb begin
      uc_sel = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (uc_pend_q[i])
            uc_sel = 2'(i);
      end
   end

   // Reference change beats software writes; user controls wait.
   assign send_norm = norm_pend_q;
   assign send_sw   = !norm_pend_q && sw_pend_q;
   assign send_uc   = !norm_pend_q && !sw_pend_q && win_q && |uc_pend_q;

   // Link write channel, one byte per cycle.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_valid_q <= 1'b0;
         wr_addr_q  <= 3'h0;
         wr_data_q  <= 8'h00;
      end else if (ce) begin
         wr_valid_q <= send_norm || send_sw || send_uc;
         if (send_norm) begin
            wr_addr_q <= tvs_pkg::LA_CTRL;
            wr_data_q <= {ctrl4_q[7:1], xtal_14m3};
         end else if (send_sw) begin
            wr_addr_q <= sw_addr_q;
            wr_data_q <= sw_data_q;
         end else if (send_uc) begin
            wr_addr_q <= {1'b0, uc_sel};
            wr_data_q <= uc_val_q[uc_sel];
         end
      end
   end
   assign link.wr_valid = wr_valid_q;
   assign link.wr_addr  = wr_addr_q;
   assign link.wr_data  = wr_data_q;

   //---------------------------------------------------------------------
   // Register port
   //---------------------------------------------------------------------

   // Queued writes; a new request in the send cycle stays pending.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q    <= tvs_pkg::CTRL_RST;
         en_q      <= '0;
         uc_pend_q <= 4'h0;
         uc_val_q  <= '0;
         sw_pend_q <= 1'b0;
         sw_addr_q <= 3'h0;
         sw_data_q <= 8'h00;
         ctrl4_q   <= tvs_pkg::CTRL4_RST;
      end else if (ce) begin
         if (send_uc)
            uc_pend_q[uc_sel] <= 1'b0;
         if (send_sw)
            sw_pend_q <= 1'b0;
         if (wr_hit) begin
            case (reg_addr)
               tvs_pkg::REG_CTRL:   ctrl_q <= reg_wdata[0:0];
               tvs_pkg::REG_INT_EN: en_q <= reg_wdata[tvs_pkg::NUM_EV-1:0];
               tvs_pkg::REG_UC: begin
                  uc_val_q[reg_wdata[9:8]]  <= reg_wdata[7:0];
                  uc_pend_q[reg_wdata[9:8]] <= 1'b1;
               end
               tvs_pkg::REG_OTHER: begin
                  sw_pend_q <= 1'b1;
                  sw_addr_q <= {1'b1, reg_wdata[9:8]};
                  // The reference bit stays under hardware control.
                  sw_data_q <= (reg_wdata[9:8] == 2'h0) ?
                               {reg_wdata[7:1], xtal_14m3} : reg_wdata[7:0];
                  if (reg_wdata[9:8] == 2'h0)
                     ctrl4_q <= reg_wdata[7:0];
               end
               default: ;
            endcase
         end
      end
   end

   // Event sources; the flag events support the grid set-up procedure.
   always_comb begin
      ev = '0;
      ev[tvs_pkg::EV_STD]     = std_d != std_sel;
      ev[tvs_pkg::EV_BUSERR]  = std_d == tvs_pkg::STD_BUS_ERR;
      ev[tvs_pkg::EV_RAISE]   = link.flags[tvs_pkg::FL_RAISE];
      ev[tvs_pkg::EV_LOWER]   = link.flags[tvs_pkg::FL_LOWER];
      ev[tvs_pkg::EV_UC_DONE] = send_uc;
      clr = (wr_hit && reg_addr == tvs_pkg::REG_INT_CLR) ?
            reg_wdata[tvs_pkg::NUM_EV-1:0] : '0;
      st_d = (st_q & ~clr) | ev;
   end

   // Sticky status; a set in the clear cycle survives.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         irq  <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         irq  <= |(st_d & en_q);
      end
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               tvs_pkg::REG_CTRL:   reg_rdata <= 32'(ctrl_q);
               tvs_pkg::REG_STATUS: reg_rdata <= 32'(st_q);
               tvs_pkg::REG_INT_EN: reg_rdata <= 32'(en_q);
               tvs_pkg::REG_STD:
                  reg_rdata <= 32'({xs_q, xtal_14m3, std_sel});
               tvs_pkg::REG_UC:     reg_rdata <= 32'({win_q, uc_pend_q});
               tvs_pkg::REG_FLAGS:  reg_rdata <= 32'(link.flags);
               default:             reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tvs_link_sva.sv ----
// Checker for the link between the processor end and the controller end.
`timescale 1ns/10ps
`default_nettype none
module tvs_link_sva #(
   parameter int WIN_CYC      = 50,
   parameter int SAMPLE_START = 60
) (
   input wire logic       core_clk,  // System clock.
   input wire logic       rst_n,     // Reset, active low.
   input wire logic [7:0] flags,     // Returned flags.
   input wire logic       flyback,   // Field flyback level.
   input wire logic       wr_valid,  // Control write pulse.
   input wire logic [2:0] wr_addr    // Control write address.
);
   logic        fb_q;
   logic [15:0] cnt_q;
   wire logic   ucw = wr_valid && !wr_addr[2];
   // Last flyback level, to find its rising edge.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) fb_q <= 1'b0;
      else fb_q <= flyback;
   end
   // Cycles since flyback rose, holding at all ones; all ones means none seen since reset or the count has run out.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 16'hffff;
      else if (flyback && !fb_q) cnt_q <= 16'h0000;
      else if (cnt_q != 16'hffff) cnt_q <= cnt_q + 16'h0001;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_PAL_SECAM_EXCL: assert property (!(flags[2] && flags[3]))
      else $error("pal and secam flags set together");
   AST_OK_HIGH: assert property (flags[6])
      else $error("ok flag low");
   AST_FAULT_LOW: assert property (!flags[7])
      else $error("fault flag high");
   AST_UC_AFTER_FLYBACK: assert property (ucw |-> cnt_q != 16'hffff)
      else $error("user write before any flyback");
   AST_UC_NOT_AT_RISE: assert property ($rose(flyback) |-> !ucw ##1 !ucw)
      else $error("user write before window opened");
   AST_UC_IN_WINDOW: assert property (ucw |-> cnt_q <= WIN_CYC)
      else $error("user write after window closed");
   AST_UC_BEFORE_SAMPLE: assert property (ucw |-> cnt_q < SAMPLE_START)
      else $error("user write during rgb sampling");
   AST_UC_ASCENDING: assert property (ucw && $past(ucw) |-> wr_addr > $past(wr_addr))
      else $error("user writes out of index order");
   // Main traffic seen at least once.
   cover property (ucw);
   cover property ($rose(flyback));
   cover property (flags[4] || flags[5]);
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench for the controller and processor ends.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, noisy = 1'b0;
   logic flyback_pin = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, xtal_14m3, seen;
   logic samp, bounce, samp_seen = 1'b0, bounce_seen = 1'b0;
   logic [9:0] line_count = 10'h271;
   logic [7:0] burst_level = 8'h00, pal_score = 8'h00, secam_score = 8'h00;
   logic [7:0] reg_addr = 8'h00, gv [3] = '{8'h10, 8'hf0, 8'h80};
   logic [1:0] gf [3] = '{2'h1, 2'h2, 2'h0};
   logic [23:0] black_dac = 24'h808080;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [3:0][7:0] user_ctrl, other_ctrl;
   tvs_pkg::tvs_std_type std_sel, es;
   int n_fail = 0, n_checks = 0;

   tvs_link_if link ();
   tvs_vproc_end #(.SAMPLE_START(60), .SAMPLE_LEN(10)) i_tvs_vproc_end (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .line_count(line_count),
      .burst_level(burst_level), .noisy(noisy), .pal_score(pal_score),
      .secam_score(secam_score), .black_dac(black_dac),
      .flyback_pin(flyback_pin), .link(link), .user_ctrl(user_ctrl),
      .other_ctrl(other_ctrl), .rgb_sampling(samp), .loop_bounce(bounce));
   tvs_ctrl_end #(.WIN_CYC(50), .SETTLE(2)) i_tvs_ctrl_end (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .std_sel(std_sel),
      .xtal_14m3(xtal_14m3), .link(link));
   tvs_link_sva #(.WIN_CYC(50), .SAMPLE_START(60)) i_tvs_link_sva (
      .core_clk(core_clk), .rst_n(rst_n), .flags(link.flags),
      .flyback(link.flyback), .wr_valid(link.wr_valid),
      .wr_addr(link.wr_addr));

   // Free-running clock, 100 ns period.
   always #50 core_clk = ~core_clk;

   // Sticky records of sampling and bounce, so short pulses are not missed.
   always @(posedge core_clk) begin
      if (samp === 1'b1) samp_seen <= 1'b1;
      if (bounce === 1'b1) bounce_seen <= 1'b1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   // One field: flyback held 20 cycles, then 40 cycles of picture.
   task automatic fly();
      @(posedge core_clk);
      flyback_pin <= 1'b1;
      repeat (20) @(posedge core_clk);
      flyback_pin <= 1'b0;
      repeat (40) @(posedge core_clk);
   endtask
   task end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence; pal and secam scores never both high, as on a real part.
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rc(tvs_pkg::REG_CTRL, 32'h1);
      rc(tvs_pkg::REG_INT_CLR, 32'h0);
      rc(8'h20, 32'h0);
      for (int k = 0; k < 16; k++) begin
         if (k[1] && k[0]) continue;
         line_count <= k[3] ? 10'h20d : 10'h271;
         burst_level <= k[2] ? 8'h50 : 8'h00;
         pal_score <= k[1] ? 8'h80 : 8'h00;
         secam_score <= k[0] ? 8'h80 : 8'h00;
         es = k[3] ? (k[2] ? tvs_pkg::STD_NTSC : tvs_pkg::STD_NTSC_KILL) :
              k[0] ? tvs_pkg::STD_SECAM :
              (k[2] && k[1]) ? tvs_pkg::STD_PAL : tvs_pkg::STD_KILL;
         fly();
         chk(32'(std_sel), 32'(es));
         rd(tvs_pkg::REG_STD);
         chk(32'(d[3:0]), {28'h0, k[3], es});
      end
      burst_level <= 8'h00;
      pal_score <= 8'h00;
      seen = 1'b0;
      repeat (8) begin
         fly();
         if (xtal_14m3 === 1'b0) seen = 1'b1;
      end
      chk(32'(seen), 32'h1);
      wr(tvs_pkg::REG_INT_EN, 32'h10);
      for (int i = 0; i < 4; i++)
         wr(tvs_pkg::REG_UC, {22'h0, i[1:0], 8'hc0 + i[7:0]});
      rc(tvs_pkg::REG_UC, 32'h0f);
      chk(32'(user_ctrl[3]), 32'h0);
      fly();
      for (int i = 0; i < 4; i++)
         chk(32'(user_ctrl[i]), 32'(8'hc0 + i[7:0]));
      chk(32'(irq), 32'h1);
      wr(tvs_pkg::REG_INT_CLR, 32'h10);
      rd(tvs_pkg::REG_STATUS);
      chk(32'({irq, d[4]}), 32'h0);
      wr(tvs_pkg::REG_OTHER, 32'h2a5);
      repeat (4) @(posedge core_clk);
      chk(32'(other_ctrl[2]), 32'ha5);
      burst_level <= 8'h50;
      for (int j = 0; j < 3; j++) begin
         black_dac <= {16'h8080, gv[j]};
         noisy <= j[0];
         repeat (6) @(posedge core_clk);
         rd(tvs_pkg::REG_FLAGS);
         chk(32'(d[5:4]), 32'(gf[j]));
         chk(32'(d[1]), 32'(!j[0]));
      end
      chk(32'(samp_seen), 32'h1);
      chk(32'(bounce_seen), 32'h0);
      end_of_test;
   end

   // Watchdog well beyond the roughly 1400 cycles the run needs.
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      end_of_test;
   end
endmodule
`default_nettype wire
